// >>> shared/latched_driver_pkg.sv
// Shared constants and carriers for the serial latched driver control
package latched_driver_pkg;

  // ==========================================================
  // Geometry
  localparam int unsigned NUM_CH = 8;

  // ==========================================================
  // Timing
  localparam int unsigned REF_PERIOD_NS  = 100;
  localparam int unsigned OC_GLITCH_NS   = 2000;
  localparam int unsigned OC_FILTER_CYC  = (OC_GLITCH_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam int unsigned QUIET_CYC      = 3;
  localparam int unsigned OVERTEMP_DEG_C = 165;

  // ==========================================================
  // Reset values
  localparam logic [NUM_CH-1:0] SHIFT_RST = 8'h00;
  localparam logic [NUM_CH-1:0] LATCH_RST = 8'h00;
  localparam logic [NUM_CH-1:0] OUT_RST   = 8'h00;
  localparam logic [NUM_CH-1:0] FAULT_RST = 8'h00;
  localparam logic [4:0]        FILT_RST  = 5'h00;
  localparam logic [1:0]        QUIET_RST = 2'h0;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [NUM_CH-1:0] overcurrent;
    logic              overtemp;
    logic              undervoltage_lockout;
  } prot_s;

  typedef enum logic {
    FILT_IDLE,
    FILT_TRIPPED
  } filt_state_e;

endpackage

// >>> src/latched_driver_ctrl.sv
// Control logic of an eight-channel serial-input latched driver
// Behaviour
// - Eight data latches drive eight channels, with shared clear, strobe, clock, data, enable.
// - Every channel has its own overcurrent detector that shuts only that channel.
// - A tripped channel stays off, flag low, until enable/reset goes high.
// - Overcurrent pulses shorter than two microseconds never shut a channel down.
// - Over-temperature turns all outputs off and drives the fault flag active.
// - Undervoltage lockout acts exactly like enable/reset held high.
// - Clear reaches the outputs only after clocking zeros and then a strobe.
// - Output latches load from the shift stages while strobe is high and the shift word is still.
// - Enable low lets outputs follow latches; high disables and clears faults.
// - Fault flag goes low on overcurrent or over-temperature faults.
// - The last stage appears on the serial output for chaining.
// - Serial input enters stage one on each rising clock edge; others shift on.
// - While clear is high each clock edge shifts in a zero.
// - Latches load while strobe is high and the shift word has stopped moving, and hold when strobe is low.
// - Over-temperature is not latched; recovery needs no reset pulse.
`timescale 1ns/1ns
`default_nettype none

module latched_driver_ctrl
  import latched_driver_pkg::*;
(
  input  wire logic              REF_CLK,
  input  wire logic              SYS_RST,
  input  wire logic              CE,
  input  wire logic              SER_CLK,
  input  wire logic              SER_DATA,
  input  wire logic              CLEAR,
  input  wire logic              STROBE,
  input  wire logic              OE_RESET,
  input  wire prot_s             PROT,
  input  wire logic              FLAG_I,
  output var  logic              SER_OUT,
  output var  logic [NUM_CH-1:0] OUT_ON,
  output var  logic              FLAG_O,
  output var  logic              FLAG_OE_N
);

  // ==========================================================
  // Link domain reset
  logic              lrst_meta_q;
  logic              lrst_q;

  always_ff @(posedge SER_CLK) begin
    lrst_meta_q <= SYS_RST;
    lrst_q      <= lrst_meta_q;
  end

  // ==========================================================
  // Shift register on the serial clock
  logic [NUM_CH-1:0] shift_q;
  logic [NUM_CH-1:0] shift_d;
  logic              shift_tog_q;
  wire               first_bit = CLEAR ? 1'b0 : SER_DATA;

  assign shift_d = {shift_q[NUM_CH-2:0], first_bit};

  always_ff @(posedge SER_CLK) begin
    if (lrst_q) begin
      shift_q     <= SHIFT_RST;
      shift_tog_q <= 1'b0;
    end else begin
      shift_q     <= shift_d;
      shift_tog_q <= ~shift_tog_q;
    end
  end

  assign SER_OUT = shift_q[NUM_CH-1];

  // ==========================================================
  // Pin synchronisers on the reference clock
  prot_s             prot_meta_q;
  prot_s             prot_q;
  logic              strobe_meta_q;
  logic              strobe_q;
  logic              oe_meta_q;
  logic              oe_q;

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      prot_meta_q   <= '0;
      prot_q        <= '0;
      strobe_meta_q <= 1'b0;
      strobe_q      <= 1'b0;
      oe_meta_q     <= 1'b1;
      oe_q          <= 1'b1;
    end else if (CE) begin
      prot_meta_q   <= PROT;
      prot_q        <= prot_meta_q;
      strobe_meta_q <= STROBE;
      strobe_q      <= strobe_meta_q;
      oe_meta_q     <= OE_RESET;
      oe_q          <= oe_meta_q;
    end
  end

  // ==========================================================
  // Shift word crossing into the reference domain
  logic [NUM_CH-1:0] word_meta_q;
  logic [NUM_CH-1:0] word_q;
  logic              tog_meta_q;
  logic              tog_q;
  logic              tog_seen_q;
  logic [1:0]        quiet_q;
  logic [1:0]        quiet_d;
  wire               tog_moved = (tog_q != tog_seen_q);
  wire               word_quiet = (quiet_q == 2'(QUIET_CYC - 1)) && !tog_moved;

  assign quiet_d = tog_moved ? QUIET_RST :
                   (quiet_q == 2'(QUIET_CYC - 1)) ? quiet_q : quiet_q + 2'h1;

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      word_meta_q <= SHIFT_RST;
      word_q      <= SHIFT_RST;
      tog_meta_q  <= 1'b0;
      tog_q       <= 1'b0;
      tog_seen_q  <= 1'b0;
      quiet_q     <= QUIET_RST;
    end else if (CE) begin
      word_meta_q <= shift_q;
      word_q      <= word_meta_q;
      tog_meta_q  <= shift_tog_q;
      tog_q       <= tog_meta_q;
      tog_seen_q  <= tog_q;
      quiet_q     <= quiet_d;
    end
  end

  // ==========================================================
  // Output latches
  logic [NUM_CH-1:0] latch_q;
  wire               latch_load = strobe_q && word_quiet;

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      latch_q <= LATCH_RST;
    end else if (CE && latch_load) begin
      latch_q <= word_q;
    end
  end

  // ==========================================================
  // Protection and per-channel drive
  wire               disable_all = oe_q || prot_q.undervoltage_lockout;
  wire               drive_ok    = !disable_all && !prot_q.overtemp;
  logic [NUM_CH-1:0] oc_trip;
  logic [NUM_CH-1:0] fault_q;
  logic [NUM_CH-1:0] fault_d;
  logic [NUM_CH-1:0] out_d;

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch = ch + 1) begin : g_chan
      oc_glitch_filter u_filter (
        .clk  (REF_CLK),
        .rst  (SYS_RST),
        .ce   (CE),
        .raw  (PROT.overcurrent[ch]),
        .trip (oc_trip[ch])
      );

      assign fault_d[ch] = oc_trip[ch] || (fault_q[ch] && !disable_all);
      assign out_d[ch]   = latch_q[ch] && !fault_q[ch] && drive_ok;

      // Shadow run count of the synchronised overcurrent level
      logic [4:0]        run_q;
      logic [4:0]        run_d;

      assign run_d = !prot_q.overcurrent[ch] ? FILT_RST :
                     (run_q == 5'(OC_FILTER_CYC)) ? run_q : run_q + 5'h01;

      always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
          run_q <= FILT_RST;
        end else if (CE) begin
          run_q <= run_d;
        end
      end

      a_trip_count: assert property (
        @(posedge REF_CLK) disable iff (SYS_RST)
        oc_trip[ch] == (run_q == 5'(OC_FILTER_CYC))
      ) else $error("Overcurrent trip does not match the qualified run length");

      a_trip_latch: assert property (
        @(posedge REF_CLK) disable iff (SYS_RST)
        (CE && oc_trip[ch]) |=> fault_q[ch]
      ) else $error("Tripped channel did not latch its fault");

      a_chan_off: assert property (
        @(posedge REF_CLK) disable iff (SYS_RST)
        (CE && fault_q[ch]) |=> !OUT_ON[ch]
      ) else $error("Faulted channel still on");
    end
  endgenerate

  wire               any_fault = (|fault_q) || prot_q.overtemp;

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      fault_q   <= FAULT_RST;
      OUT_ON    <= OUT_RST;
      FLAG_O    <= 1'b0;
      FLAG_OE_N <= 1'b1;
    end else if (CE) begin
      fault_q   <= fault_d;
      OUT_ON    <= out_d;
      FLAG_O    <= 1'b0;
      FLAG_OE_N <= !any_fault;
    end
  end

  // ==========================================================
  // Checks on the serial clock
  a_shift_clear: assert property (
    @(posedge SER_CLK) disable iff (lrst_q)
    CLEAR |=> (shift_q[0] == 1'b0)
  ) else $error("Clear did not shift in a zero");

  a_shift_move: assert property (
    @(posedge SER_CLK) disable iff (lrst_q)
    !CLEAR |=> (shift_q == {$past(shift_q[NUM_CH-2:0]), $past(SER_DATA)})
  ) else $error("Serial input not shifted into stage one");

  a_chain_out: assert property (
    @(posedge SER_CLK) disable iff (lrst_q)
    1'b1 |=> (SER_OUT == $past(shift_q[NUM_CH-2]))
  ) else $error("Serial output is not the shifted-through bit");

  a_shift_toggle: assert property (
    @(posedge SER_CLK) disable iff (lrst_q)
    1'b1 |=> (shift_tog_q != $past(shift_tog_q))
  ) else $error("Shift marker did not toggle on a serial clock edge");

  a_clear_all: assert property (
    @(posedge SER_CLK) disable iff (lrst_q)
    CLEAR [*8] |=> (shift_q == '0)
  ) else $error("Eight cleared edges left a stage set");

  // ==========================================================
  // Checks on the reference clock
  a_latch_load: assert property (
    @(posedge REF_CLK) disable iff (SYS_RST)
    (CE && latch_load) |=> (latch_q == $past(word_q))
  ) else $error("Latches did not load while strobe high");

  a_latch_hold: assert property (
    @(posedge REF_CLK) disable iff (SYS_RST)
    (CE && !strobe_q) |=> $stable(latch_q)
  ) else $error("Latches changed with strobe low");

  a_disable_off: assert property (
    @(posedge REF_CLK) disable iff (SYS_RST)
    (CE && disable_all) |=> (OUT_ON == '0)
  ) else $error("Outputs on while disabled");

  a_lockout_clear: assert property (
    @(posedge REF_CLK) disable iff (SYS_RST)
    (CE && prot_q.undervoltage_lockout && oc_trip == '0) |=> (fault_q == '0) && (OUT_ON == '0)
  ) else $error("Undervoltage did not clear faults and outputs");

  a_channel_off: assert property (
    @(posedge REF_CLK) disable iff (SYS_RST)
    (CE && fault_q != '0) |=> ((OUT_ON & $past(fault_q)) == '0)
  ) else $error("Faulted channel still driven");

  a_fault_holds: assert property (
    @(posedge REF_CLK) disable iff (SYS_RST)
    (CE && !disable_all && fault_q != '0) |=> ((fault_q & $past(fault_q)) == $past(fault_q))
  ) else $error("Overcurrent fault released without reset");

  a_temp_off: assert property (
    @(posedge REF_CLK) disable iff (SYS_RST)
    (CE && prot_q.overtemp) |=> (OUT_ON == '0) && !FLAG_OE_N
  ) else $error("Over-temperature did not shut down");

  a_flag_fault: assert property (
    @(posedge REF_CLK) disable iff (SYS_RST)
    (CE && fault_q != '0) |=> !FLAG_OE_N && !FLAG_O
  ) else $error("Fault flag not driven on overcurrent");

  a_temp_recover: assert property (
    @(posedge REF_CLK) disable iff (SYS_RST)
    (CE && !prot_q.overtemp && fault_q == '0) |=> FLAG_OE_N
  ) else $error("Flag stuck after temperature cleared");

  a_clear_path: assert property (
    @(posedge REF_CLK) disable iff (SYS_RST)
    (CE && !latch_load) |=> ($past(latch_q) == latch_q)
  ) else $error("Latches changed without strobe");

  a_trip_sets: assert property (
    @(posedge REF_CLK) disable iff (SYS_RST)
    (CE && oc_trip != '0) |=> ((fault_q & $past(oc_trip)) == $past(oc_trip))
  ) else $error("Overcurrent trip lost against a clear");

  a_oe_release: assert property (
    @(posedge REF_CLK) disable iff (SYS_RST)
    (CE && disable_all) |=> ((fault_q & ~$past(oc_trip)) == '0)
  ) else $error("Disable did not clear latched faults");

  a_own_channel: assert property (
    @(posedge REF_CLK) disable iff (SYS_RST)
    CE |=> ((fault_q & ~$past(fault_q) & ~$past(oc_trip)) == '0)
  ) else $error("Fault set on a channel without its own trip");

  a_out_follow: assert property (
    @(posedge REF_CLK) disable iff (SYS_RST)
    (CE && drive_ok && fault_q == '0) |=> (OUT_ON == $past(latch_q))
  ) else $error("Outputs do not follow the latches while enabled");

  a_out_latched: assert property (
    @(posedge REF_CLK) disable iff (SYS_RST)
    CE |=> ((OUT_ON & ~$past(latch_q)) == '0)
  ) else $error("Output on without its latch set");

  a_strobe_wait: assert property (
    @(posedge REF_CLK) disable iff (SYS_RST)
    (CE && tog_moved) |=> $stable(latch_q)
  ) else $error("Latches loaded while the shift word was moving");

  a_temp_unlatched: assert property (
    @(posedge REF_CLK) disable iff (SYS_RST)
    (CE && prot_q.overtemp && oc_trip == '0 && fault_q == '0) |=> (fault_q == '0)
  ) else $error("Over-temperature was latched as a fault");

  a_temp_release: assert property (
    @(posedge REF_CLK) disable iff (SYS_RST)
    (CE && prot_q.overtemp) ##1 (CE && !prot_q.overtemp && fault_q == '0) |=> FLAG_OE_N
  ) else $error("Flag not released after over-temperature ended");

  a_uv_like_oe: assert property (
    @(posedge REF_CLK) disable iff (SYS_RST)
    (CE && prot_q.undervoltage_lockout) |=> (OUT_ON == '0) && ((fault_q & ~$past(oc_trip)) == '0)
  ) else $error("Undervoltage did not act as disable");

  a_reset_off: assert property (
    @(posedge REF_CLK)
    SYS_RST |=> (OUT_ON == '0) && FLAG_OE_N && !FLAG_O
  ) else $error("Outputs or flag active during reset");

endmodule // latched_driver_ctrl

`default_nettype wire

// >>> src/oc_glitch_filter.sv
// Overcurrent glitch filter for one driver channel
`timescale 1ns/1ns
`default_nettype none

module oc_glitch_filter
  import latched_driver_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic raw,
  output var  logic trip
);

  // ==========================================================
  // Input synchroniser
  logic        meta_q;
  logic        sync_q;
  logic [4:0]  cnt_q;
  logic [4:0]  cnt_d;
  filt_state_e state_q;
  filt_state_e state_d;
  wire         long_enough = (cnt_q == 5'(OC_FILTER_CYC - 1));

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else if (ce) begin
      meta_q <= raw;
      sync_q <= meta_q;
    end
  end

  // ==========================================================
  // Run-length count and trip state
  always_comb begin
    cnt_d   = cnt_q;
    state_d = state_q;
    case (state_q)
      FILT_IDLE: begin
        if (!sync_q) begin
          cnt_d = FILT_RST;
        end else if (long_enough) begin
          state_d = FILT_TRIPPED;
        end else begin
          cnt_d = cnt_q + 5'h01;
        end
      end
      FILT_TRIPPED: begin
        if (!sync_q) begin
          state_d = FILT_IDLE;
          cnt_d   = FILT_RST;
        end
      end
      default: state_d = FILT_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q   <= FILT_RST;
      state_q <= FILT_IDLE;
    end else if (ce) begin
      cnt_q   <= cnt_d;
      state_q <= state_d;
    end
  end

  assign trip = (state_q == FILT_TRIPPED);

  // ==========================================================
  // Checks
  a_short_ignored: assert property (
    @(posedge clk) disable iff (rst)
    (ce && !sync_q && state_q == FILT_IDLE) |=> !trip
  ) else $error("Overcurrent trip without a qualified pulse");

endmodule // oc_glitch_filter

`default_nettype wire

// >>> verification/latched_driver_ctrl_tb.sv
// Self-checking testbench for the serial latched driver control
`timescale 1ns/1ns
`default_nettype none

module latched_driver_ctrl_tb;
  import latched_driver_pkg::*;

  logic              ref_clk;
  logic              sys_rst;
  logic              ce;
  logic              oe_reset;
  prot_s             prot;
  wire logic         ser_clk, ser_data, clear, strobe;
  wire logic         flag_pin;
  logic              ser_out, flag_o, flag_oe_n;
  logic [NUM_CH-1:0] out_on;
  logic              probe;
  logic              exp_so;
  logic [9:0]        notes[$];
  logic [9:0]        cur;
  logic [7:0]        w1, w2;
  int                bad_count;
  int                samples_checked;

  // ==========================================================
  // Clock, flag wire with pull-up, design and host
  initial ref_clk = 1'b0;
  always #50 ref_clk = ~ref_clk;
  assign flag_pin = flag_oe_n ? 1'b1 : flag_o;

  latched_driver_ctrl DUT (
    .REF_CLK(ref_clk), .SYS_RST(sys_rst), .CE(ce), .SER_CLK(ser_clk), .SER_DATA(ser_data),
    .CLEAR(clear), .STROBE(strobe), .OE_RESET(oe_reset), .PROT(prot), .FLAG_I(flag_pin),
    .SER_OUT(ser_out), .OUT_ON(out_on), .FLAG_O(flag_o), .FLAG_OE_N(flag_oe_n)
  );

  serial_host_model host (
    .ser_clk(ser_clk), .ser_data(ser_data), .clear(clear), .strobe(strobe)
  );

  // ==========================================================
  // Comparison, verdict and expectation notes
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    if (bad_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic note(input logic [7:0] on, input logic fl);
    repeat (30) @(posedge ref_clk);
    notes.push_back({on, fl, exp_so});
    probe <= 1'b1;
    @(posedge ref_clk);
    probe <= 1'b0;
  endtask

  always @(posedge ref_clk) begin
    if (probe) begin
      cur = notes.pop_front();
      check("OUT_ON", out_on, cur[9:2]);
      check("FLAG_OE_N", {7'h00, flag_oe_n}, {7'h00, cur[1]});
      check("SER_OUT", {7'h00, ser_out}, {7'h00, cur[0]});
    end
  end

  task automatic load(input logic [7:0] w);
    host.send(w, 1'b0);
    exp_so = w[7];
    host.strobe_pulse();
  endtask

  initial begin
    #2_000_000;
    bad_count++;
    wrap_up();
  end

  // ==========================================================
  // Main sequence
  initial begin
    sys_rst = 1'b1;
    ce = 1'b1;
    oe_reset = 1'b0;
    prot = '0;
    probe = 1'b0;
    exp_so = 1'b0;
    bad_count = 0;
    samples_checked = 0;
    void'($urandom(32'hec15ca62));
    fork
      host.send(8'h00, 1'b0);
      repeat (5) @(posedge ref_clk);
    join
    sys_rst <= 1'b0;
    // Link reset releases only after two serial edges: flush them first
    host.send(8'h00, 1'b0);
    note(8'h00, 1'b1);
    w1 = 8'($urandom);
    w2 = 8'($urandom);
    load(w1);
    note(w1, 1'b1);
    host.send(w2, 1'b0);
    exp_so = w2[7];
    note(w1, 1'b1);
    host.strobe_pulse();
    note(w2, 1'b1);
    @(posedge ref_clk) oe_reset <= 1'b1;
    note(8'h00, 1'b1);
    @(posedge ref_clk) oe_reset <= 1'b0;
    note(w2, 1'b1);
    host.send(8'hff, 1'b1);
    exp_so = 1'b0;
    note(w2, 1'b1);
    host.strobe_pulse();
    note(8'h00, 1'b1);
    load(8'hff);
    @(posedge ref_clk) prot.overcurrent[3] <= 1'b1;
    repeat (OC_FILTER_CYC - 1) @(posedge ref_clk);
    prot.overcurrent[3] <= 1'b0;
    note(8'hff, 1'b1);
    for (int i = 0; i < NUM_CH; i++) begin
      @(posedge ref_clk) prot.overcurrent[i] <= 1'b1;
      note(8'hff & ~(8'h01 << i), 1'b0);
      prot.overcurrent[i] <= 1'b0;
      note(8'hff & ~(8'h01 << i), 1'b0);
      oe_reset <= 1'b1;
      note(8'h00, 1'b1);
      oe_reset <= 1'b0;
      note(8'hff, 1'b1);
    end
    @(posedge ref_clk) prot.overtemp <= 1'b1;
    note(8'h00, 1'b0);
    prot.overtemp <= 1'b0;
    note(8'hff, 1'b1);
    prot.overcurrent[5] <= 1'b1;
    note(8'hdf, 1'b0);
    prot.overcurrent[5] <= 1'b0;
    prot.undervoltage_lockout <= 1'b1;
    note(8'h00, 1'b1);
    prot.undervoltage_lockout <= 1'b0;
    note(8'hff, 1'b1);
    ce <= 1'b0;
    oe_reset <= 1'b1;
    note(8'hff, 1'b1);
    ce <= 1'b1;
    note(8'h00, 1'b1);
    oe_reset <= 1'b0;
    note(8'hff, 1'b1);
    repeat (3) @(posedge ref_clk);
    wrap_up();
  end
endmodule // latched_driver_ctrl_tb

`default_nettype wire

// >>> verification/serial_host_model.sv
// Host model driving the serial link, clear and strobe lines
`timescale 1ns/1ns
`default_nettype none

module serial_host_model (
  output var logic ser_clk,
  output var logic ser_data,
  output var logic clear,
  output var logic strobe
);
  // ==========================================================
  // Idle levels: link clock stands still outside frames
  initial begin
    ser_clk  = 1'b0;
    ser_data = 1'b1;
    clear    = 1'b0;
    strobe   = 1'b0;
  end

  // ==========================================================
  // Frame of eight bits at 48 ns, first bit ends in the last stage
  task automatic send(input logic [7:0] word, input logic clr);
    #7;
    for (int i = 7; i >= 0; i--) begin
      ser_data = word[i];
      clear    = clr;
      #24 ser_clk = 1'b1;
      #24 ser_clk = 1'b0;
    end
    clear    = 1'b0;
    ser_data = ~ser_data;  // Released line shows no stale value
  endtask

  // ==========================================================
  // Strobe after a gap from the last clock, wide enough to be seen
  task automatic strobe_pulse();
    #500 strobe = 1'b1;
    #1000 strobe = 1'b0;
  endtask
endmodule // serial_host_model

`default_nettype wire
